// ### dtd_pkg.sv
// package: constants and types for the data transfer decode block
package dtd_pkg;
  localparam logic [7:0] DTD_INDIRECT_PAGE = 8'h00;
  localparam logic [7:0] DTD_SHORT_PAGE = 8'hff;
  localparam logic [15:0] DTD_STEP_BYTE = 16'h0001;
  localparam logic [15:0] DTD_STEP_WORD = 16'h0002;
  localparam logic [2:0] DTD_SP_INDEX = 3'h7;
  localparam int DTD_NUM_INSTR = 57;
  localparam int DTD_NUM_CLASS = 8;

  typedef enum logic [2:0]
  {
    DTD_CLS_TRANSFER = 3'h0,
    DTD_CLS_ARITH = 3'h1,
    DTD_CLS_LOGIC = 3'h2,
    DTD_CLS_SHIFT = 3'h3,
    DTD_CLS_BIT = 3'h4,
    DTD_CLS_BRANCH = 3'h5,
    DTD_CLS_SYSTEM = 3'h6,
    DTD_CLS_BLOCK = 3'h7
  } dtd_class_t;

  // operation codes presented by the core decoder
  typedef enum logic [3:0]
  {
    DTD_OP_TRANSFER = 4'h0,
    DTD_OP_PUSH = 4'h1,
    DTD_OP_POP = 4'h2,
    DTD_OP_JUMP_IND = 4'h3,
    DTD_OP_PSYNC_WR = 4'h4,
    DTD_OP_PSYNC_RD = 4'h5,
    DTD_OP_ARITH = 4'h6,
    DTD_OP_LOGIC = 4'h7,
    DTD_OP_SHIFT = 4'h8,
    DTD_OP_BIT = 4'h9,
    DTD_OP_BRANCH = 4'ha,
    DTD_OP_BCOND = 4'hb,
    DTD_OP_SYSTEM = 4'hc,
    DTD_OP_BLOCK = 4'hd,
    DTD_OP_CCR_PUSH = 4'he,
    DTD_OP_CCR_POP = 4'hf
  } dtd_op_t;

  typedef enum logic [2:0]
  {
    DTD_AM_REG = 3'h0,
    DTD_AM_IND = 3'h1,
    DTD_AM_DISP = 3'h2,
    DTD_AM_ABS16 = 3'h3,
    DTD_AM_IMM = 3'h4,
    DTD_AM_PREDEC = 3'h5,
    DTD_AM_POSTINC = 3'h6,
    DTD_AM_SHORT = 3'h7
  } dtd_mode_t;

  typedef enum logic [2:0]
  {
    DTD_ST_IDLE = 3'b000,
    DTD_ST_ADDR = 3'b001,
    DTD_ST_ACCESS = 3'b011,
    DTD_ST_WAIT = 3'b010,
    DTD_ST_DONE = 3'b110
  } dtd_state_t;
endpackage : dtd_pkg

// ### dtd_ea_calc.sv
// effective address former and address register update
`timescale 1ns/10ps
module dtd_ea_calc
  import dtd_pkg::*;
(
  input wire dtd_pkg::dtd_mode_t mode_in,
  input wire logic word_in,
  input wire logic indirect_in,
  input wire logic [15:0] base_in,
  input wire logic [15:0] disp_in,
  input wire logic [7:0] abs8_in,
  output logic [15:0] addr_out,
  output logic [15:0] base_next_out,
  output logic base_write_out
);
  function automatic logic [15:0] align_word(input logic [15:0] a, input logic w);
    align_word = w ? {a[15:1], 1'b0} : a;
  endfunction : align_word

  logic [15:0] step;
  logic [15:0] raw;

  always_comb
  begin
    step = word_in ? DTD_STEP_WORD : DTD_STEP_BYTE;
    base_next_out = base_in;
    base_write_out = 1'b0;
    raw = base_in;
    if (indirect_in)
    begin
      raw = {DTD_INDIRECT_PAGE, abs8_in};
    end
    else
    begin
      case (mode_in)
        DTD_AM_DISP: raw = base_in + disp_in;
        DTD_AM_ABS16: raw = disp_in;
        DTD_AM_SHORT: raw = {DTD_SHORT_PAGE, abs8_in};
        DTD_AM_PREDEC:
        begin
          raw = base_in - step;
          base_next_out = raw;
          base_write_out = 1'b1;
        end
        DTD_AM_POSTINC:
        begin
          base_next_out = base_in + step;
          base_write_out = 1'b1;
        end
        default: raw = base_in;
      endcase
    end
    addr_out = align_word(raw, word_in | indirect_in);
  end
endmodule : dtd_ea_calc

// ### dtd_core.sv
// data transfer decode and execute unit with instruction classifier
// How it works
// - a memory-indirect jump reads the word at 00:abs8 and uses it as the target.
// - a push decrements the stack pointer by two then writes the register there.
// - a pop reads the word at the stack pointer then adds two to it.
// - transfers take register, indirect, displacement, absolute16, immediate, pre-dec and post-inc modes in both sizes.
// - the short absolute mode is accepted only for byte transfers.
// - the peripheral-synchronised byte transfers are not provided and are refused.
// - a transfer copies between registers, register and memory, or immediate into a register.
// - all 57 instructions are sorted into eight functional classes.
// - the conditional branch carries a condition field picking its condition test.
// - word accesses force address bit zero low with no error.
// - the stack is only word wide; flags push twice and pop ignores the low byte.
// - pre-decrement and post-increment step by one for bytes and two for words.
// - short absolute addresses have an upper byte of all ones.
`timescale 1ns/10ps
module dtd_core
  import dtd_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic start_in,
  input wire dtd_pkg::dtd_op_t op_in,
  input wire dtd_pkg::dtd_mode_t mode_in,
  input wire logic word_in,
  input wire logic to_mem_in,
  input wire logic [2:0] reg_sel_in,
  input wire logic [2:0] base_sel_in,
  input wire logic [15:0] ext_in,
  input wire logic [7:0] abs8_in,
  input wire logic [3:0] cond_in,
  input wire logic [15:0] reg_data_in,
  input wire logic [15:0] base_data_in,
  input wire logic [7:0] flags_in,
  input wire logic [15:0] mem_rdata_in,
  input wire logic mem_ack_in,
  output logic busy_out,
  output logic done_out,
  output logic illegal_out,
  output dtd_pkg::dtd_class_t class_out,
  output logic [3:0] cond_sel_out,
  output logic mem_req_out,
  output logic mem_we_out,
  output logic mem_word_out,
  output logic [15:0] mem_addr_out,
  output logic [15:0] mem_wdata_out,
  output logic rd_we_out,
  output logic [2:0] rd_sel_out,
  output logic [15:0] rd_data_out,
  output logic rd_word_out,
  output logic base_we_out,
  output logic [2:0] base_sel_out,
  output logic [15:0] base_data_out,
  output logic flags_we_out,
  output logic [7:0] flags_data_out,
  output logic pc_we_out,
  output logic [15:0] pc_data_out
);
  import dtd_pkg::*;
  typedef struct packed
  {
    dtd_state_t st;
    logic busy;
    logic done;
    logic illegal;
    dtd_class_t cls;
    logic [3:0] cond;
    dtd_op_t op;
    dtd_mode_t mode;
    logic word;
    logic to_mem;
    logic ind;
    logic [2:0] rsel;
    logic [2:0] bsel;
    logic [15:0] wdata;
    logic [15:0] ext;
    logic [7:0] abs8;
    logic [15:0] base;
    logic mreq;
    logic mwe;
    logic mword;
    logic [15:0] maddr;
    logic rwe;
    logic [15:0] rdata;
    logic rword;
    logic bwe;
    logic [15:0] bdata;
    logic fwe;
    logic [7:0] fdata;
    logic pwe;
    logic [15:0] pdata;
  } dtd_state_reg_t;
  dtd_state_reg_t s_reg;
  dtd_state_reg_t s_next;
  logic [15:0] ea_addr;
  logic [15:0] ea_base_next;
  logic ea_base_write;
  function automatic dtd_class_t classify(input dtd_op_t op);
    case (op)
      DTD_OP_ARITH: classify = DTD_CLS_ARITH;
      DTD_OP_LOGIC: classify = DTD_CLS_LOGIC;
      DTD_OP_SHIFT: classify = DTD_CLS_SHIFT;
      DTD_OP_BIT: classify = DTD_CLS_BIT;
      DTD_OP_BRANCH, DTD_OP_BCOND, DTD_OP_JUMP_IND: classify = DTD_CLS_BRANCH;
      DTD_OP_SYSTEM: classify = DTD_CLS_SYSTEM;
      DTD_OP_BLOCK: classify = DTD_CLS_BLOCK;
      default: classify = DTD_CLS_TRANSFER;
    endcase
  endfunction : classify
  function automatic logic [15:0] fit_size(input logic [15:0] d, input logic w);
    fit_size = w ? d : {8'h00, d[7:0]};
  endfunction : fit_size
  ////////////////////////////////////////////////////////////////////////////
  dtd_ea_calc u_ea
  (
    .mode_in(s_reg.mode),
    .word_in(s_reg.word),
    .indirect_in(s_reg.ind),
    .base_in(s_reg.base),
    .disp_in(s_reg.ext),
    .abs8_in(s_reg.abs8),
    .addr_out(ea_addr),
    .base_next_out(ea_base_next),
    .base_write_out(ea_base_write)
  );
  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.rwe = 1'b0;
    s_next.bwe = 1'b0;
    s_next.fwe = 1'b0;
    s_next.pwe = 1'b0;
    case (s_reg.st)
      DTD_ST_IDLE:
      begin
        s_next.illegal = 1'b0;
        if (start_in)
        begin
          s_next.cls = classify(op_in);
          s_next.cond = (op_in == DTD_OP_BCOND) ? cond_in : 4'h0;
          s_next.op = op_in;
          s_next.mode = mode_in;
          s_next.word = word_in;
          s_next.to_mem = to_mem_in;
          s_next.ind = 1'b0;
          s_next.rsel = reg_sel_in;
          s_next.bsel = base_sel_in;
          s_next.wdata = reg_data_in;
          s_next.ext = ext_in;
          s_next.abs8 = abs8_in;
          s_next.base = base_data_in;
          s_next.busy = 1'b1;
          s_next.st = DTD_ST_ADDR;
          case (op_in)
            DTD_OP_PUSH, DTD_OP_CCR_PUSH:
            begin
              s_next.mode = DTD_AM_PREDEC;
              s_next.to_mem = 1'b1;
              s_next.word = 1'b1;
              s_next.bsel = DTD_SP_INDEX;
              if (op_in == DTD_OP_CCR_PUSH)
              begin
                s_next.wdata = {flags_in, flags_in};
              end
            end
            DTD_OP_POP, DTD_OP_CCR_POP:
            begin
              s_next.mode = DTD_AM_POSTINC;
              s_next.to_mem = 1'b0;
              s_next.word = 1'b1;
              s_next.bsel = DTD_SP_INDEX;
            end
            DTD_OP_JUMP_IND:
            begin
              s_next.ind = 1'b1;
              s_next.mode = DTD_AM_IND;
              s_next.to_mem = 1'b0;
              s_next.word = 1'b1;
            end
            DTD_OP_TRANSFER:
            begin
              // no word short absolute form; immediate is a source only
              if ((mode_in == DTD_AM_SHORT && word_in)
                || (to_mem_in && mode_in == DTD_AM_IMM))
              begin
                s_next.illegal = 1'b1;
                s_next.st = DTD_ST_DONE;
              end
            end
            default:
            begin
              s_next.illegal = (op_in == DTD_OP_PSYNC_WR) || (op_in == DTD_OP_PSYNC_RD);
              s_next.st = DTD_ST_DONE;
            end
          endcase
        end
      end
      DTD_ST_ADDR:
      begin
        if (s_reg.mode == DTD_AM_REG || s_reg.mode == DTD_AM_IMM)
        begin
          s_next.rwe = ~s_reg.to_mem;
          s_next.rword = s_reg.word;
          s_next.rdata = fit_size(s_reg.mode == DTD_AM_IMM ? s_reg.ext : s_reg.wdata, s_reg.word);
          s_next.st = DTD_ST_DONE;
        end
        else
        begin
          s_next.mreq = 1'b1;
          s_next.mwe = s_reg.to_mem;
          s_next.mword = s_reg.word;
          s_next.maddr = ea_addr;
          s_next.bdata = ea_base_next;
          s_next.bwe = ea_base_write & ~s_reg.ind;
          s_next.st = DTD_ST_ACCESS;
        end
      end
      DTD_ST_ACCESS:
      begin
        if (mem_ack_in)
        begin
          s_next.mreq = 1'b0;
          s_next.mwe = 1'b0;
          if (s_reg.ind)
          begin
            s_next.pwe = 1'b1;
            s_next.pdata = mem_rdata_in;
          end
          else if (s_reg.op == DTD_OP_CCR_POP)
          begin
            s_next.fwe = 1'b1;
            s_next.fdata = mem_rdata_in[15:8];
          end
          else if (!s_reg.to_mem)
          begin
            s_next.rwe = 1'b1;
            s_next.rword = s_reg.word;
            s_next.rdata = fit_size(mem_rdata_in, s_reg.word);
          end
          s_next.st = DTD_ST_WAIT;
        end
      end
      DTD_ST_WAIT:
      begin
        s_next.st = DTD_ST_DONE;
      end
      DTD_ST_DONE:
      begin
        s_next.done = 1'b1;
        s_next.busy = 1'b0;
        s_next.st = DTD_ST_IDLE;
      end
      default:
      begin
        s_next.st = DTD_ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    busy_out = s_reg.busy;
    done_out = s_reg.done;
    illegal_out = s_reg.illegal;
    class_out = s_reg.cls;
    cond_sel_out = s_reg.cond;
    mem_req_out = s_reg.mreq;
    mem_we_out = s_reg.mwe;
    mem_word_out = s_reg.mword;
    mem_addr_out = s_reg.maddr;
    mem_wdata_out = s_reg.wdata;
    rd_we_out = s_reg.rwe;
    rd_sel_out = s_reg.rsel;
    rd_data_out = s_reg.rdata;
    rd_word_out = s_reg.rword;
    base_we_out = s_reg.bwe;
    base_sel_out = s_reg.bsel;
    base_data_out = s_reg.bdata;
    flags_we_out = s_reg.fwe;
    flags_data_out = s_reg.fdata;
    pc_we_out = s_reg.pwe;
    pc_data_out = s_reg.pdata;
  end
endmodule : dtd_core

// ### dtd_core_properties.sv
// checker: port timing and addressing of the data transfer unit
`timescale 1ns/10ps
module dtd_core_chk
  import dtd_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic start_in,
  input wire dtd_pkg::dtd_op_t op_in,
  input wire dtd_pkg::dtd_mode_t mode_in,
  input wire logic word_in,
  input wire logic [7:0] abs8_in,
  input wire logic [15:0] base_data_in,
  input wire logic mem_ack_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic illegal_out,
  input wire logic mem_req_out,
  input wire logic mem_we_out,
  input wire logic mem_word_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic base_we_out,
  input wire logic [2:0] base_sel_out,
  input wire logic [15:0] base_data_out
);
  logic take;
  logic xfer;
  assign take = start_in && !busy_out && !done_out;
  assign xfer = take && op_in == DTD_OP_TRANSFER;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////
  property p_word_even;
    mem_req_out && mem_word_out |-> !mem_addr_out[0];
  endproperty
  a_word_even: assert property (p_word_even) else $error("odd word address");
  property p_push;
    take && op_in == DTD_OP_PUSH |-> ##2 mem_req_out && mem_we_out && mem_word_out
      && base_we_out && base_sel_out == 3'h7
      && mem_addr_out == (($past(base_data_in, 2) - 16'h0002) & 16'hfffe)
      && base_data_out == $past(base_data_in, 2) - 16'h0002;
  endproperty
  a_push: assert property (p_push) else $error("push access wrong");
  property p_pop;
    take && op_in == DTD_OP_POP |-> ##2 mem_req_out && !mem_we_out && mem_word_out
      && base_we_out && base_sel_out == 3'h7
      && mem_addr_out == ($past(base_data_in, 2) & 16'hfffe)
      && base_data_out == $past(base_data_in, 2) + 16'h0002;
  endproperty
  a_pop: assert property (p_pop) else $error("pop access wrong");
  property p_jump;
    take && op_in == DTD_OP_JUMP_IND |-> ##2 mem_req_out && !mem_we_out && mem_word_out
      && mem_addr_out == ({8'h00, $past(abs8_in, 2)} & 16'hfffe);
  endproperty
  a_jump: assert property (p_jump) else $error("indirect address wrong");
  property p_short;
    xfer && mode_in == DTD_AM_SHORT && !word_in |-> ##2 mem_req_out && !mem_word_out
      && mem_addr_out == {8'hff, $past(abs8_in, 2)};
  endproperty
  a_short: assert property (p_short) else $error("short address wrong");
  property p_short_word;
    xfer && mode_in == DTD_AM_SHORT && word_in |-> ##1 !mem_req_out
      ##1 done_out && illegal_out && !mem_req_out;
  endproperty
  a_short_word: assert property (p_short_word) else $error("word short taken");
  property p_psync;
    take && (op_in == DTD_OP_PSYNC_WR || op_in == DTD_OP_PSYNC_RD) |-> ##1 !mem_req_out
      ##1 done_out && illegal_out && !mem_req_out;
  endproperty
  a_psync: assert property (p_psync) else $error("sync transfer taken");
  property p_predec;
    xfer && mode_in == DTD_AM_PREDEC |-> ##2 base_we_out
      && base_data_out == $past(base_data_in, 2) - ($past(word_in, 2) ? 16'h0002 : 16'h0001);
  endproperty
  a_predec: assert property (p_predec) else $error("decrement step wrong");
  property p_ack;
    mem_req_out && mem_ack_in |=> !mem_req_out ##2 done_out;
  endproperty
  a_ack: assert property (p_ack) else $error("no finish after ack");
endmodule : dtd_core_chk

bind dtd_core dtd_core_chk i_dtd_core_chk (.ref_clk_in, .sys_rst_in, .start_in, .op_in,
  .mode_in, .word_in, .abs8_in, .base_data_in, .mem_ack_in, .busy_out, .done_out,
  .illegal_out, .mem_req_out, .mem_we_out, .mem_word_out, .mem_addr_out, .base_we_out,
  .base_sel_out, .base_data_out);

// ### dtd_mem_model.sv
// behavioural program and data memory on the internal bus
`timescale 1ns/10ps
module dtd_mem_model
(
  input wire logic ref_clk_in,
  input wire logic [3:0] lat_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire logic word_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out,
  output logic ack_out
);
  logic [7:0] mem [0:65535];
  logic [15:0] a;
  logic [3:0] cnt = 4'h0;
  assign a = {addr_in[15:1], 1'b0};
  initial
  begin
    ack_out = 1'b0;
    rdata_out = 16'h0000;
  end
  // answers after lat_in idle cycles; read bus toggles while not answering
  always @(posedge ref_clk_in)
  begin
    ack_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (req_in && !ack_out)
    begin
      cnt <= cnt + 4'h1;
      if (cnt >= lat_in)
      begin
        cnt <= 4'h0;
        ack_out <= 1'b1;
        rdata_out <= word_in ? {mem[a], mem[a + 16'h1]} : {8'h00, mem[addr_in]};
        if (we_in && word_in)
          {mem[a], mem[a + 16'h1]} <= wdata_in;
        else if (we_in)
          mem[addr_in] <= wdata_in[7:0];
      end
    end
  end
endmodule : dtd_mem_model

// ### cpu_data_transfer_decode_bench.sv
// testbench: data transfer unit against a behavioural memory
`timescale 1ns/10ps
module cpu_data_transfer_decode_bench;
  import dtd_pkg::*;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic start_in = 1'b0;
  dtd_op_t op_in = DTD_OP_TRANSFER;
  dtd_mode_t mode_in = DTD_AM_REG;
  logic word_in = 1'b0;
  logic to_mem_in = 1'b0;
  logic [2:0] reg_sel_in = 3'h5;
  logic [2:0] base_sel_in = 3'h2; // byte steps keep clear of register seven
  logic [15:0] ext_in = 16'h0000;
  logic [7:0] abs8_in = 8'h00;
  logic [3:0] cond_in = 4'hb;
  logic [15:0] reg_data_in = 16'h0000;
  logic [15:0] base_data_in = 16'h0000;
  logic [7:0] flags_in = 8'h00;
  logic [15:0] mem_rdata_in, mem_addr_out, mem_wdata_out, rd_data_out, base_data_out, pc_data_out;
  logic mem_ack_in, busy_out, done_out, illegal_out, mem_req_out, mem_we_out, mem_word_out;
  logic rd_we_out, rd_word_out, base_we_out, flags_we_out, pc_we_out, ill;
  dtd_class_t class_out;
  logic [3:0] cond_sel_out;
  logic [3:0] lat = 4'h0;
  logic [2:0] rd_sel_out, base_sel_out;
  logic [7:0] flags_data_out, fl_v;
  logic [15:0] rd_v, base_v, pc_v;
  int fails = 0;
  int cmp_count = 0;
  dtd_core i_dtd_core (.*);
  dtd_mem_model i_dtd_mem_model (.ref_clk_in(ref_clk_in), .lat_in(lat), .req_in(mem_req_out),
    .we_in(mem_we_out), .word_in(mem_word_out), .addr_in(mem_addr_out),
    .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in), .ack_out(mem_ack_in));
  always #20 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in)
  begin
    if (rd_we_out)
      rd_v <= rd_data_out;
    if (base_we_out)
      base_v <= base_data_out;
    if (pc_we_out)
      pc_v <= pc_data_out;
    if (flags_we_out)
      fl_v <= flags_data_out;
  end
  ////////////////////////////////////////
  function automatic logic [15:0] mw(input logic [15:0] x);
    return {i_dtd_mem_model.mem[x], i_dtd_mem_model.mem[x + 16'h1]};
  endfunction : mw
  task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task go(input dtd_op_t o);
    int i;
    @(negedge ref_clk_in);
    op_in = o;
    start_in = 1'b1;
    @(negedge ref_clk_in);
    start_in = 1'b0;
    for (i = 0; i < 60 && done_out !== 1'b1; i++)
      @(negedge ref_clk_in);
    ill = illegal_out;
    chk("done", 16'(done_out), 16'h0001);
  endtask : go
  task finish_test;
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////
  task t_stack;
    base_data_in = 16'h1000;
    reg_data_in = 16'hbeef;
    go(DTD_OP_PUSH);
    chk("push", mw(16'h0ffe), 16'hbeef);
    chk("push sp", base_v, 16'h0ffe);
    lat = 4'h3;
    base_data_in = 16'h0ffe;
    go(DTD_OP_POP);
    chk("pop", rd_v, 16'hbeef);
    chk("pop sp", base_v, 16'h1000);
    chk("pop reg", 16'(rd_sel_out), 16'h0005);
  endtask : t_stack
  task t_flags;
    base_data_in = 16'h2000;
    flags_in = 8'ha5;
    go(DTD_OP_CCR_PUSH);
    chk("flag push", mw(16'h1ffe), 16'ha5a5);
    i_dtd_mem_model.mem[16'h1fff] = 8'h11;
    base_data_in = 16'h1ffe;
    go(DTD_OP_CCR_POP);
    chk("flag pop", 16'(fl_v), 16'h00a5);
  endtask : t_flags
  task t_jump;
    i_dtd_mem_model.mem[16'h0040] = 8'h12;
    i_dtd_mem_model.mem[16'h0041] = 8'h34;
    abs8_in = 8'h41;
    go(DTD_OP_JUMP_IND);
    chk("target", pc_v, 16'h1234);
  endtask : t_jump
  task t_short;
    to_mem_in = 1'b1;
    mode_in = DTD_AM_SHORT;
    abs8_in = 8'h20;
    reg_data_in = 16'h005a;
    go(DTD_OP_TRANSFER);
    chk("short", mw(16'hff20) >> 8, 16'h005a);
    chk("short ok", 16'(ill), 16'h0000);
    word_in = 1'b1;
    go(DTD_OP_TRANSFER);
    chk("short word", 16'(ill), 16'h0001);
    mode_in = DTD_AM_ABS16;
    ext_in = 16'h3001;
    reg_data_in = 16'h7788;
    go(DTD_OP_TRANSFER);
    chk("odd word", mw(16'h3000), 16'h7788);
    mode_in = DTD_AM_IMM;
    go(DTD_OP_TRANSFER);
    chk("imm store", 16'(ill), 16'h0001);
    go(DTD_OP_PSYNC_WR);
    chk("sync wr", 16'(ill), 16'h0001);
    go(DTD_OP_PSYNC_RD);
    chk("sync rd", 16'(ill), 16'h0001);
  endtask : t_short
  task t_step;
    word_in = 1'b0;
    mode_in = DTD_AM_PREDEC;
    base_data_in = 16'h2001;
    reg_data_in = 16'h00c3;
    go(DTD_OP_TRANSFER);
    chk("dec mem", mw(16'h2000) >> 8, 16'h00c3);
    chk("dec ptr", base_v, 16'h2000);
    to_mem_in = 1'b0;
    mode_in = DTD_AM_POSTINC;
    base_data_in = 16'h2000;
    go(DTD_OP_TRANSFER);
    chk("inc byte", rd_v, 16'h00c3);
    chk("inc ptr b", base_v, 16'h2001);
    word_in = 1'b1;
    base_data_in = 16'h0ffe;
    go(DTD_OP_TRANSFER);
    chk("inc word", rd_v, 16'hbeef);
    chk("rd word", 16'(rd_word_out), 16'h0001);
    chk("inc ptr w", base_v, 16'h1000);
  endtask : t_step
  task t_modes;
    lat = 4'h1;
    ext_in = 16'h1234;
    for (int w = 0; w < 2; w++)
      for (int m = 0; m < 7; m++)
      begin
        word_in = w[0];
        mode_in = dtd_mode_t'(m[2:0]);
        go(DTD_OP_TRANSFER);
        chk("mode ok", 16'(ill), 16'h0000);
        if (m == 4)
          chk("imm", rd_v, w[0] ? 16'h1234 : 16'h0034);
      end
  endtask : t_modes
  task t_class;
    dtd_op_t ops [9];
    dtd_class_t cls [9];
    ops = '{DTD_OP_ARITH, DTD_OP_LOGIC, DTD_OP_SHIFT, DTD_OP_BIT, DTD_OP_BRANCH, DTD_OP_BCOND,
      DTD_OP_SYSTEM, DTD_OP_BLOCK, DTD_OP_TRANSFER};
    cls = '{DTD_CLS_ARITH, DTD_CLS_LOGIC, DTD_CLS_SHIFT, DTD_CLS_BIT, DTD_CLS_BRANCH,
      DTD_CLS_BRANCH, DTD_CLS_SYSTEM, DTD_CLS_BLOCK, DTD_CLS_TRANSFER};
    mode_in = DTD_AM_REG;
    for (int k = 0; k < 9; k++)
    begin
      go(ops[k]);
      chk("class", 16'(class_out), 16'(cls[k]));
      if (k == 5)
        chk("cond", 16'(cond_sel_out), 16'h000b);
    end
  endtask : t_class
  ////////////////////////////////////////
  initial
  begin
    #400000;
    fails++;
    finish_test;
  end
  initial
  begin
    repeat (12) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    t_stack;
    t_flags;
    t_jump;
    t_short;
    t_step;
    t_modes;
    t_class;
    finish_test;
  end
endmodule : cpu_data_transfer_decode_bench
